// ==== hw/synth_latch_pkg.sv ====
package synth_latch_pkg;

    localparam int WORD_W = 21;
    localparam int SEL_W = 2;

    // destination select codes in bits 1..0
    localparam logic [1:0] SEL_REF = 2'h0;
    localparam logic [1:0] SEL_DIV = 2'h1;
    localparam logic [1:0] SEL_FUNC = 2'h2;
    localparam logic [1:0] SEL_INIT = 2'h3;

    // divider latch layout
    localparam int SWALLOW_LSB = 2;
    localparam int SWALLOW_W = 5;
    localparam int MAIN_LSB = 7;
    localparam int MAIN_W = 13;
    localparam int GAIN_POS = 20;

    // function / initialization latch layout
    localparam int CNT_RST_POS = 2;
    localparam int PD_REQ_POS = 3;
    localparam int MUX_LSB = 4;
    localparam int MUX_W = 3;
    localparam int POLARITY_POS = 7;
    localparam int TRISTATE_POS = 8;
    localparam int FL_EN_POS = 9;
    localparam int VARIANT_POS = 11;
    localparam int TIMEOUT_LSB = 12;
    localparam int TIMEOUT_W = 4;
    localparam int PD_SYNC_POS = 19;

    // reset values of the stored latches
    localparam logic [WORD_W-1:0] WORD_RESET = 21'h000000;
    localparam logic [WORD_W-3:0] REF_RESET = 19'h00000;

    // fastlock timeout: detector cycles per step of the timer field
    localparam int TIMEOUT_STEP = 4;
    localparam int TIMER_W = 12;

    // lock detect needs this many good detector cycles in a row
    localparam logic [1:0] LOCK_GOOD_CYCLES = 2'h3;

    typedef struct packed {
        logic gain;
        logic [MAIN_W-1:0] main_count;
        logic [SWALLOW_W-1:0] swallow_count;
    } divider_t;

    typedef struct packed {
        logic pd_sync;
        logic [TIMEOUT_W-1:0] timeout;
        logic variant;
        logic fl_en;
        logic tristate;
        logic polarity;
        logic [MUX_W-1:0] mux_sel;
        logic pd_req;
        logic cnt_rst;
    } func_t;

    typedef struct packed {
        logic event_seen;
        logic err_small;
        logic err_large;
    } detector_t;

    localparam func_t FUNC_RESET = '0;
    localparam divider_t DIV_RESET = '0;

endpackage : synth_latch_pkg

// ==== hw/synth_control_latches.sv ====
// Summary of operation
// - serial bits shift into a 21-bit register, msb first, on each serial clock rise
// - load strobe rising edge copies the register into one destination latch
// - two low bits pick reference, divider, function or initialization latch
// - lock sets after three good detector cycles, clears on one bad cycle
// - divider latch holds swallow, main count and gain flag
// - select code two loads the function latch
// - counter reset bit holds reference, swallow and main counters in reset
// - counters restart together once the counter reset bit clears
// - power-down bits act only while chip enable is high
// - chip enable low powers down at once regardless of power-down bits
// - request bit set with sync select clear powers down immediately
// - both bits set power down after the next charge-pump event
// - any power-down resets counters, timer, lock detect and tristates pump
// - serial register keeps shifting and latching during power-down
// - three mux select bits route an internal signal to the mux pin
// - polarity bit sets detector polarity; host writes it per tuning slope
// - tristate bit set puts the charge pump in three-state
// - fastlock acts only while its enable bit is set
// - variant bit picks manual exit or timer exit fastlock
// - with fastlock disabled the fastlock pin copies the variant bit
// - manual fastlock: gain flag one drives pin low and high current
// - timed fastlock clears the gain flag itself after the timeout
// - initialization load sets function settings and pulses counter reset
// - initialization with sync power-down and chip enable high triggers it
// - first divider load after initialization repeats the reset pulse
`timescale 1ns/1ps
module synth_control_latches
    import synth_latch_pkg::*;
#(
    parameter int STEP = TIMEOUT_STEP
) (
    input wire logic CORE_CLK_I,
    input wire logic RESET_I,
    input wire logic SER_CLK_I,
    input wire logic SER_DATA_I,
    input wire logic LOAD_STROBE_I,
    input wire logic CHIP_ENABLE_I,
    input wire logic DETECTOR_EVENT_I,
    input wire logic PHASE_ERR_SMALL_I,
    input wire logic PHASE_ERR_LARGE_I,
    output logic [WORD_W-3:0] REF_LATCH_O,
    output logic [SWALLOW_W-1:0] SWALLOW_COUNT_O,
    output logic [MAIN_W-1:0] MAIN_COUNT_O,
    output logic COUNTER_RESET_O,
    output logic POWERDOWN_O,
    output logic PUMP_TRISTATE_O,
    output logic PUMP_HIGH_CURRENT_O,
    output logic DETECTOR_POLARITY_O,
    output logic FASTLOCK_SWITCH_O,
    output logic LOCK_DETECT_O,
    output logic TEST_MUX_O
);

    // timeout in detector cycles for a timer field value
    function automatic logic [TIMER_W-1:0] timeout_cycles(input logic [TIMEOUT_W-1:0] field);
        timeout_cycles = TIMER_W'((int'(field) + 1) * STEP);
    endfunction : timeout_cycles

    // two-stage synchronisers, plus one edge-history stage for serial clock, load strobe and detector event
    logic [2:0] sck_q;
    logic [1:0] sda_q;
    logic [2:0] le_q;
    logic [1:0] ce_q;
    logic [2:0] det_q;
    logic [1:0] small_q;
    logic [1:0] large_q;

    // serial port pins
    always_ff @(posedge CORE_CLK_I) begin
        if (RESET_I) begin
            sck_q <= 3'h0;
            sda_q <= 2'h0;
            le_q <= 3'h0;
        end else begin
            sck_q <= {sck_q[1:0], SER_CLK_I};
            sda_q <= {sda_q[0], SER_DATA_I};
            le_q <= {le_q[1:0], LOAD_STROBE_I};
        end
    end

    // chip enable resets low so the block comes out of reset powered down
    always_ff @(posedge CORE_CLK_I) begin
        if (RESET_I) begin
            ce_q <= 2'h0;
        end else begin
            ce_q <= {ce_q[0], CHIP_ENABLE_I};
        end
    end

    // detector event and its error levels share one delay so they stay aligned
    always_ff @(posedge CORE_CLK_I) begin
        if (RESET_I) begin
            det_q <= 3'h0;
            small_q <= 2'h0;
            large_q <= 2'h0;
        end else begin
            det_q <= {det_q[1:0], DETECTOR_EVENT_I};
            small_q <= {small_q[0], PHASE_ERR_SMALL_I};
            large_q <= {large_q[0], PHASE_ERR_LARGE_I};
        end
    end

    logic sck_rise;
    logic le_rise;
    logic ce_high;
    detector_t det;

    assign sck_rise = sck_q[1] & ~sck_q[2];
    assign le_rise = le_q[1] & ~le_q[2];
    assign ce_high = ce_q[1];
    assign det.event_seen = det_q[1] & ~det_q[2];
    assign det.err_small = small_q[1];
    assign det.err_large = large_q[1];

    // serial input register, never gated by power-down
    logic [WORD_W-1:0] shift_q;

    always_ff @(posedge CORE_CLK_I) begin
        if (RESET_I) begin
            shift_q <= WORD_RESET;
        end else if (sck_rise) begin
            shift_q <= {shift_q[WORD_W-2:0], sda_q[1]};
        end
    end

    logic [1:0] dest;
    logic load_ref;
    logic load_div;
    logic load_func;
    logic load_init;

    assign dest = shift_q[SEL_W-1:0];
    assign load_ref = le_rise && dest == SEL_REF;
    assign load_div = le_rise && dest == SEL_DIV;
    assign load_func = le_rise && dest == SEL_FUNC;
    assign load_init = le_rise && dest == SEL_INIT;

    // destination latches
    logic [WORD_W-3:0] ref_q;
    divider_t div_q;
    func_t func_q;
    func_t func_d;

    always_comb begin
        func_d.cnt_rst = shift_q[CNT_RST_POS];
        func_d.pd_req = shift_q[PD_REQ_POS];
        func_d.mux_sel = shift_q[MUX_LSB +: MUX_W];
        func_d.polarity = shift_q[POLARITY_POS];
        func_d.tristate = shift_q[TRISTATE_POS];
        func_d.fl_en = shift_q[FL_EN_POS];
        func_d.variant = shift_q[VARIANT_POS];
        func_d.timeout = shift_q[TIMEOUT_LSB +: TIMEOUT_W];
        func_d.pd_sync = shift_q[PD_SYNC_POS];
    end

    always_ff @(posedge CORE_CLK_I) begin
        if (RESET_I) begin
            ref_q <= REF_RESET;
        end else if (load_ref) begin
            ref_q <= shift_q[WORD_W-1:SEL_W];
        end
    end

    always_ff @(posedge CORE_CLK_I) begin
        if (RESET_I) begin
            func_q <= FUNC_RESET;
        end else if (load_func || load_init) begin
            func_q <= func_d;
        end
    end

    // fastlock state and timer
    logic fl_active;
    logic timer_done;
    logic [TIMER_W-1:0] timer_q;
    logic powerdown;

    assign fl_active = func_q.fl_en & div_q.gain;
    assign timer_done = fl_active && func_q.variant && det.event_seen
        && timer_q >= timeout_cycles(func_q.timeout) - TIMER_W'(1);

    always_ff @(posedge CORE_CLK_I) begin
        if (RESET_I) begin
            div_q <= DIV_RESET;
        end else if (load_div) begin
            // a new write wins over the timer's own clear
            div_q.swallow_count <= shift_q[SWALLOW_LSB +: SWALLOW_W];
            div_q.main_count <= shift_q[MAIN_LSB +: MAIN_W];
            div_q.gain <= shift_q[GAIN_POS];
        end else if (timer_done) begin
            div_q.gain <= 1'b0;
        end
    end

    always_ff @(posedge CORE_CLK_I) begin
        if (RESET_I) begin
            timer_q <= '0;
        end else if (powerdown || !fl_active || !func_q.variant || load_div) begin
            timer_q <= '0;
        end else if (det.event_seen) begin
            timer_q <= timer_q + TIMER_W'(1);
        end
    end

    // initialization pulse and the armed repeat on the next divider load
    logic init_pulse_q;
    logic first_div_pending_q;

    always_ff @(posedge CORE_CLK_I) begin
        if (RESET_I) begin
            init_pulse_q <= 1'b0;
        end else begin
            init_pulse_q <= load_init || (load_div && first_div_pending_q);
        end
    end

    always_ff @(posedge CORE_CLK_I) begin
        if (RESET_I) begin
            first_div_pending_q <= 1'b0;
        end else if (load_init) begin
            first_div_pending_q <= 1'b1;
        end else if (load_div) begin
            first_div_pending_q <= 1'b0;
        end
    end

    // power-down control
    logic async_pd;
    logic sync_armed;
    logic sync_pd_q;

    assign async_pd = func_q.pd_req & ~func_q.pd_sync;
    assign sync_armed = func_q.pd_req & func_q.pd_sync & ce_high;

    always_ff @(posedge CORE_CLK_I) begin
        if (RESET_I) begin
            sync_pd_q <= 1'b0;
        end else if (!sync_armed) begin
            sync_pd_q <= 1'b0;
        end else if (det.event_seen || init_pulse_q) begin
            sync_pd_q <= 1'b1;
        end
    end

    assign powerdown = !ce_high || async_pd || sync_pd_q;

    // digital lock detect
    logic [1:0] good_q;
    logic lock_q;

    always_ff @(posedge CORE_CLK_I) begin
        if (RESET_I || powerdown) begin
            good_q <= 2'h0;
            lock_q <= 1'b0;
        end else if (det.event_seen) begin
            if (det.err_large) begin
                good_q <= 2'h0;
                lock_q <= 1'b0;
            end else if (det.err_small) begin
                if (good_q != LOCK_GOOD_CYCLES) begin
                    good_q <= good_q + 2'h1;
                end
                if (good_q == LOCK_GOOD_CYCLES - 2'h1) begin
                    lock_q <= 1'b1;
                end
            end else if (!lock_q) begin
                good_q <= 2'h0;
            end
        end
    end

    // registered outputs
    logic cnt_reset;
    logic mux_value;

    assign cnt_reset = func_q.cnt_rst || powerdown || init_pulse_q;

    always_comb begin
        case (func_q.mux_sel)
            3'h0: mux_value = 1'b0;
            3'h1: mux_value = lock_q;
            3'h2: mux_value = cnt_reset;
            3'h3: mux_value = 1'b1;
            3'h4: mux_value = powerdown;
            3'h5: mux_value = fl_active;
            3'h6: mux_value = det.event_seen;
            default: mux_value = shift_q[WORD_W-1];
        endcase
    end

    // divider and reference values as loaded
    always_ff @(posedge CORE_CLK_I) begin
        if (RESET_I) begin
            REF_LATCH_O <= REF_RESET;
            SWALLOW_COUNT_O <= '0;
            MAIN_COUNT_O <= '0;
        end else begin
            REF_LATCH_O <= ref_q;
            SWALLOW_COUNT_O <= div_q.swallow_count;
            MAIN_COUNT_O <= div_q.main_count;
        end
    end

    // reset values keep the loop quiet while reset is held
    always_ff @(posedge CORE_CLK_I) begin
        if (RESET_I) begin
            COUNTER_RESET_O <= 1'b1;
            POWERDOWN_O <= 1'b1;
            PUMP_TRISTATE_O <= 1'b1;
        end else begin
            COUNTER_RESET_O <= cnt_reset;
            POWERDOWN_O <= powerdown;
            PUMP_TRISTATE_O <= func_q.tristate || powerdown || init_pulse_q;
        end
    end

    // pump current and fastlock pin move in the same cycle
    always_ff @(posedge CORE_CLK_I) begin
        if (RESET_I) begin
            PUMP_HIGH_CURRENT_O <= 1'b0;
            FASTLOCK_SWITCH_O <= 1'b0;
        end else begin
            PUMP_HIGH_CURRENT_O <= fl_active;
            FASTLOCK_SWITCH_O <= func_q.fl_en ? ~fl_active : func_q.variant;
        end
    end

    always_ff @(posedge CORE_CLK_I) begin
        if (RESET_I) begin
            DETECTOR_POLARITY_O <= 1'b0;
        end else begin
            DETECTOR_POLARITY_O <= func_q.polarity;
        end
    end

    // status seen by the host
    always_ff @(posedge CORE_CLK_I) begin
        if (RESET_I) begin
            LOCK_DETECT_O <= 1'b0;
            TEST_MUX_O <= 1'b0;
        end else begin
            LOCK_DETECT_O <= lock_q;
            TEST_MUX_O <= mux_value;
        end
    end

endmodule : synth_control_latches

// ==== bench/host_serial_model.sv ====
`timescale 1ns/1ps
module host_serial_model (
    input wire logic clk_i,
    output logic ser_clk_o,
    output logic ser_data_o,
    output logic strobe_o
);
    initial begin
        ser_clk_o = 1'b0;
        ser_data_o = 1'b0;
        strobe_o = 1'b0;
    end
    // serial clock stands low outside frames, data changes mid-low
    task automatic send(input logic [20:0] w);
        @(posedge clk_i);
        #1;
        for (int i = 20; i >= 0; i--) begin
            ser_clk_o = 1'b0;
            #200 ser_data_o = w[i];
            #200 ser_clk_o = 1'b1;
            #400;
        end
        ser_clk_o = 1'b0;
        strobe_o = 1'b1;
        #400 strobe_o = 1'b0;
        // released data line no longer shows the last bit
        ser_data_o = ~ser_data_o;
    endtask : send
endmodule : host_serial_model

// ==== bench/synth_latches_sva.sv ====
`timescale 1ns/1ps
module synth_latches_sva
    import synth_latch_pkg::*;
(
    input wire logic CORE_CLK_I,
    input wire logic RESET_I,
    input wire logic LOAD_STROBE_I,
    input wire logic CHIP_ENABLE_I,
    input wire logic DETECTOR_EVENT_I,
    input wire logic [WORD_W-3:0] REF_LATCH_O,
    input wire logic [SWALLOW_W-1:0] SWALLOW_COUNT_O,
    input wire logic [MAIN_W-1:0] MAIN_COUNT_O,
    input wire logic COUNTER_RESET_O,
    input wire logic POWERDOWN_O,
    input wire logic PUMP_TRISTATE_O,
    input wire logic PUMP_HIGH_CURRENT_O,
    input wire logic DETECTOR_POLARITY_O,
    input wire logic FASTLOCK_SWITCH_O,
    input wire logic LOCK_DETECT_O
);
    default clocking @(posedge CORE_CLK_I); endclocking
    default disable iff (RESET_I);
    sequence quiet_s;
        !LOAD_STROBE_I [*8];
    endsequence
    sequence ce_off_s;
        !CHIP_ENABLE_I [*5];
    endsequence
    sequence pd_s;
        POWERDOWN_O [*2];
    endsequence
    ce_low_pd_a: assert property (ce_off_s |-> POWERDOWN_O)
        else $error("no power-down with chip enable low");
    pd_cntrst_a: assert property (pd_s |-> COUNTER_RESET_O)
        else $error("counters not held in power-down");
    pd_tristate_a: assert property (pd_s |-> PUMP_TRISTATE_O)
        else $error("pump driven in power-down");
    pd_nolock_a: assert property (pd_s |-> !LOCK_DETECT_O)
        else $error("lock kept in power-down");
    latch_hold_a: assert property (quiet_s |->
        $stable({REF_LATCH_O, SWALLOW_COUNT_O, MAIN_COUNT_O, DETECTOR_POLARITY_O}))
        else $error("latch changed without load strobe");
    gain_hold_a: assert property (quiet_s |-> !$rose(PUMP_HIGH_CURRENT_O))
        else $error("high current without a write");
    lock_quiet_a: assert property (!DETECTOR_EVENT_I [*8] |-> !$rose(LOCK_DETECT_O))
        else $error("lock rose without detector cycles");
    fl_pin_low_a: assert property (PUMP_HIGH_CURRENT_O |-> !FASTLOCK_SWITCH_O)
        else $error("fastlock pin high during fastlock");
endmodule : synth_latches_sva

// ==== bench/testbench.sv ====
`timescale 1ns/1ps
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin failures++; $display("BAD t=%0t got %h exp %h", $time, a, b); end end
module testbench;
    import synth_latch_pkg::*;
    typedef struct packed {
        logic [WORD_W-1:0] word;
        logic [18:0] exp;
    } row_t;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic ce = 1'b1;
    logic ev = 1'b0;
    logic es = 1'b0;
    logic el = 1'b0;
    wire logic sck, sda, sle;
    logic [WORD_W-3:0] ref_o;
    logic [SWALLOW_W-1:0] sw_o;
    logic [MAIN_W-1:0] main_o;
    logic cr_o, pd_o, tri_o, hc_o, pol_o, fl_o, lk_o, mux_o;
    int failures = 0;
    int n_tests = 0;
    int n_cr = 0;
    row_t rows [8] = '{'{21'h169694, 19'h5A5A5}, '{21'h1FFFFC, 19'h7FFFF}, '{21'h0D5E55, 19'h35795},
        '{21'h0FFFFD, 19'h3FFFF}, '{21'h000882, 19'h00005}, '{21'h100072, 19'h00008},
        '{21'h000026, 19'h00008}, '{21'h000132, 19'h0000A}};
    always #50 clk = ~clk;
    always @(posedge clk) if (cr_o !== 1'b0) n_cr++;
    host_serial_model i_host (.clk_i(clk), .ser_clk_o(sck), .ser_data_o(sda), .strobe_o(sle));
    synth_control_latches #(.STEP(1)) i_dut (.CORE_CLK_I(clk), .RESET_I(rst), .SER_CLK_I(sck),
        .SER_DATA_I(sda), .LOAD_STROBE_I(sle), .CHIP_ENABLE_I(ce), .DETECTOR_EVENT_I(ev),
        .PHASE_ERR_SMALL_I(es), .PHASE_ERR_LARGE_I(el), .REF_LATCH_O(ref_o), .SWALLOW_COUNT_O(sw_o),
        .MAIN_COUNT_O(main_o), .COUNTER_RESET_O(cr_o), .POWERDOWN_O(pd_o), .PUMP_TRISTATE_O(tri_o),
        .PUMP_HIGH_CURRENT_O(hc_o), .DETECTOR_POLARITY_O(pol_o), .FASTLOCK_SWITCH_O(fl_o),
        .LOCK_DETECT_O(lk_o), .TEST_MUX_O(mux_o));
    task automatic step(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : step
    task automatic wr(input logic [WORD_W-1:0] w);
        i_host.send(w);
        step(4);
    endtask : wr
    task automatic det(input logic s, input logic l);
        es = s;
        el = l;
        ev = 1'b1;
        step(4);
        ev = 1'b0;
        step(4);
    endtask : det
    function automatic logic [18:0] obs(input logic [1:0] s);
        case (s)
            SEL_REF: return ref_o;
            SEL_DIV: return {1'b0, main_o, sw_o};
            default: return {15'h0000, mux_o, pol_o, tri_o, fl_o};
        endcase
    endfunction : obs
    task automatic tally_and_finish;
        $display("failures=%0d n_tests=%0d", failures, n_tests);
        if (failures == 0 && n_tests > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : tally_and_finish
    initial begin
        step(2);
        `CHK({cr_o, pd_o, tri_o, lk_o, hc_o}, 5'h1C)
        rst = 1'b0;
        step(6);
        for (int i = 0; i < 8; i++) begin
            wr(rows[i].word);
            `CHK(obs(rows[i].word[1:0]), rows[i].exp)
        end
        // reset pulse on init load and on the first divider load only
        n_cr = 0;
        wr(21'h000003);
        `CHK(n_cr, 1)
        n_cr = 0;
        wr(21'h000001);
        `CHK(n_cr, 1)
        n_cr = 0;
        wr(21'h000001);
        `CHK(n_cr, 0)
        wr(21'h000006);
        `CHK(cr_o, 1'b1)
        wr(21'h000002);
        `CHK(cr_o, 1'b0)
        wr(21'h00004A);
        `CHK({pd_o, tri_o, cr_o, mux_o}, 4'hF)
        wr(21'h0FFFFD);
        `CHK(main_o, 13'h1FFF)
        wr(21'h000002);
        `CHK(pd_o, 1'b0)
        wr(21'h08000A);
        `CHK(pd_o, 1'b0)
        det(1'b0, 1'b0);
        `CHK(pd_o, 1'b1)
        wr(21'h000002);
        wr(21'h08000B);
        `CHK(pd_o, 1'b1)
        wr(21'h000012);
        ce = 1'b0;
        step(6);
        `CHK(pd_o, 1'b1)
        ce = 1'b1;
        step(6);
        `CHK(pd_o, 1'b0)
        det(1'b1, 1'b0);
        det(1'b1, 1'b0);
        `CHK(lk_o, 1'b0)
        det(1'b1, 1'b0);
        `CHK({lk_o, mux_o}, 2'h3)
        det(1'b0, 1'b1);
        `CHK(lk_o, 1'b0)
        // timer field 1 with one cycle per step: two detector cycles
        wr(21'h001A02);
        `CHK({hc_o, fl_o}, 2'h1)
        wr(21'h100001);
        `CHK({hc_o, fl_o}, 2'h2)
        det(1'b0, 1'b0);
        `CHK(hc_o, 1'b1)
        det(1'b0, 1'b0);
        `CHK({hc_o, fl_o}, 2'h1)
        wr(21'h000252);
        wr(21'h100001);
        repeat (3) det(1'b0, 1'b0);
        `CHK({hc_o, mux_o}, 2'h3)
        wr(21'h000001);
        `CHK({hc_o, fl_o}, 2'h1)
        wr(21'h000002);
        wr(21'h100001);
        `CHK({hc_o, fl_o}, 2'h0)
        tally_and_finish;
    end
endmodule : testbench
bind synth_control_latches synth_latches_sva i_sva (.CORE_CLK_I(CORE_CLK_I), .RESET_I(RESET_I),
    .LOAD_STROBE_I(LOAD_STROBE_I), .CHIP_ENABLE_I(CHIP_ENABLE_I), .DETECTOR_EVENT_I(DETECTOR_EVENT_I),
    .REF_LATCH_O(REF_LATCH_O), .SWALLOW_COUNT_O(SWALLOW_COUNT_O), .MAIN_COUNT_O(MAIN_COUNT_O),
    .COUNTER_RESET_O(COUNTER_RESET_O), .POWERDOWN_O(POWERDOWN_O), .PUMP_TRISTATE_O(PUMP_TRISTATE_O),
    .PUMP_HIGH_CURRENT_O(PUMP_HIGH_CURRENT_O), .DETECTOR_POLARITY_O(DETECTOR_POLARITY_O),
    .FASTLOCK_SWITCH_O(FASTLOCK_SWITCH_O), .LOCK_DETECT_O(LOCK_DETECT_O));
